//--- rtl/afe_ctrl_pkg.sv
// Purpose: Types for the control register group
// Assumes: Nothing
// Notes:   Field codes of the mux and pin selectors
package afe_ctrl_pkg;
    typedef enum logic [1:0] {
        MUX_OFF,
        MUX_CO_AMP,
        MUX_PHOTO_GAIN,
        MUX_PHOTODIODE
    } mux_choice_type;

    typedef enum logic [2:0] {
        PIN_HIZ,
        PIN_RSVD1,
        PIN_ERR_OUT,
        PIN_RSVD3,
        PIN_OR_LED_A,
        PIN_OR_LED_B,
        PIN_RSVD6,
        PIN_OR_BATTERY
    } pin_mode_type;

    typedef struct packed {
        logic       write_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_type;

    typedef struct packed {
        logic boost_on;
        logic led_block_on;
        logic horn_block_on;
        logic host_regulator_on;
        logic brownout_monitor_on;
        logic fault_enter;
        logic overtemp_error_flag;
        logic mux_buffer_on;
        logic mux_bypass_on;
        logic analog_shutoff;
    } block_ctrl_type;
endpackage

`default_nettype wire

//--- rtl/afe_ctrl_regs.svh
// Purpose: Offsets, field positions and reset values of the control register group
// Assumes: Byte-wide registers reached over the serial register port
// Notes:   Definitions only
`ifndef AFE_CTRL_REGS_SVH
`define AFE_CTRL_REGS_SVH
`define OFF_ENABLE_TWO      8'h07
`define OFF_CONTROL         8'h08
`define OFF_SLEEP_DUR_HIGH  8'h09
`define OFF_SLEEP_DUR_LOW   8'h0A
`define OFF_PIN_MUX         8'h0B
`define RST_BYTE            8'h00
`define MASK_ENABLE_TWO     8'hCF
`define MASK_CONTROL        8'h3F
`define MASK_PIN_MUX        8'hB7
`define BIT_LED_SOURCE      7
`define BIT_BOOST_CHARGE    6
`define BIT_INT_DIR         3
`define BIT_LED_PIN_GATE    2
`define BIT_HORN_EN         1
`define BIT_SLEEP_START     0
`define BIT_REG_OFF         5
`define BIT_BROWNOUT_OFF    4
`define BIT_REG_ERR_OFF     3
`define BIT_OVERTEMP_EN     2
`define BIT_SOFT_CLEAR      1
`define BIT_BROWNOUT_BOOST  0
`define BIT_MUX_BYPASS      7
`define MUX_SEL_HI          5
`define MUX_SEL_LO          4
`define PIN_SEL_HI          2
`define PIN_SEL_LO          0
`define MS_TIME_NS          1000000
`define CLK_PERIOD_NS       10
`define MS_CYCLES           (`MS_TIME_NS / `CLK_PERIOD_NS)
`define DUR_ZERO            16'h0000
`define DUR_ONE             16'h0001
`endif

//--- rtl/afe_ctrl_sleep_regs.sv
// Purpose: Control, sleep timer and pin/mux register group of an alarm front end
// Assumes: Serial port already decoded into one-cycle byte accesses; 100 MHz clock
// Notes:   Millisecond tick derived here from the clock
// What this block does
// - Source bit picks LED A or B input
// - Charge bit forces boost until power good
// - After charge, boost follows main enable and brownout assist
// - Direction bit routes interconnect signal either way
// - Gate bit lets LED pin enable block
// - Horn bit lets horn pin enable horn
// - Sleep timer expiry sets done, clears start
// - Writing zero to start ends sleep early
// - Sixteen-bit duration counts whole milliseconds
// - Duration change applies at next sleep start
// - Zero duration disables; later change starts timer
// - Disable bits turn regulator and monitor off
// - Regulator error faults unless disabled
// - Overtemperature faults and flags when enabled
// - Soft clear resets registers except boost charge bit
// - Brownout assist enables boost on brownout
// - Two-bit mux select picks analog source
// - Bypass bit swaps buffer for switch
// - Pin code zero floats, two drives
// - Output code drives high on unmasked error
// - Input codes OR pin into enables
// - Sleep analog shutoff forces mux, horn, battery test and interconnect off
`include "afe_ctrl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module afe_ctrl_sleep_regs #(
    parameter int MS_CYCLES = `MS_CYCLES
) (
    input  wire logic                        CLK,
    input  wire logic                        RESETN,
    input  wire afe_ctrl_pkg::reg_access_type REG_ACCESS,
    output logic [7:0]                       REG_RDATA,
    input  wire logic                        SLEEP_ANALOG_SHUTOFF,
    input  wire logic                        LED_A_ENABLE_INPUT,
    input  wire logic                        LED_B_ENABLE_INPUT,
    input  wire logic                        LED_ENABLE_PIN,
    input  wire logic                        HORN_ENABLE_PIN,
    input  wire logic                        BOOST_MAIN_ENABLE,
    input  wire logic                        BOOST_POWER_GOOD,
    input  wire logic                        BROWNOUT_INDICATION,
    input  wire logic                        REGULATOR_ERROR,
    input  wire logic                        OVERTEMP_EVENT,
    input  wire logic                        ANY_UNMASKED_ERROR,
    input  wire logic                        BATTERY_LOAD_ENABLE,
    input  wire logic                        INT_UNIT_IN,
    input  wire logic                        INT_MCU_IN,
    output logic                             INT_UNIT_OUT,
    output logic                             INT_UNIT_OE,
    output logic                             INT_MCU_OUT,
    output logic                             INT_MCU_OE,
    input  wire logic                        MPIN_IN,
    output logic                             MPIN_OUT,
    output logic                             MPIN_OE,
    output logic                             LED_A_ON,
    output logic                             LED_B_ON,
    output logic                             BATTERY_TEST_ON,
    output logic [1:0]                       MUX_SELECT,
    output logic                             SLEEP_ACTIVE,
    output logic                             SLEEP_FINISHED_FLAG,
    output logic                             SOFT_CLEAR_PULSE,
    output afe_ctrl_pkg::block_ctrl_type      BLOCK_CTRL
);
    import afe_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  enable_two_reg,  enable_two_next;
    logic [7:0]  control_reg,     control_next;
    logic [7:0]  dur_high_reg,    dur_high_next;
    logic [7:0]  dur_low_reg,     dur_low_next;
    logic [7:0]  pin_mux_reg,     pin_mux_next;
    logic [15:0] remain_reg,      remain_next;
    logic [31:0] tick_cnt_reg,    tick_cnt_next;
    logic        running_reg,     running_next;
    logic        done_reg,        done_next;
    logic        charging_reg,    charging_next;
    logic        otemp_flag_reg,  otemp_flag_next;

    logic        wr_en;
    logic        ms_tick;
    logic        soft_clear;
    logic        start_written;
    logic        dur_written;
    logic [15:0] dur_value;
    logic [7:0]  dur_high_in;
    logic [7:0]  dur_low_in;
    logic        sleep_start;

    assign wr_en         = REG_ACCESS.write_en;
    assign soft_clear    = wr_en && REG_ACCESS.addr == `OFF_CONTROL
                           && REG_ACCESS.wdata[`BIT_SOFT_CLEAR];
    assign start_written = wr_en && REG_ACCESS.addr == `OFF_ENABLE_TWO
                           && REG_ACCESS.wdata[`BIT_SLEEP_START];
    assign dur_written   = wr_en && (REG_ACCESS.addr == `OFF_SLEEP_DUR_HIGH
                           || REG_ACCESS.addr == `OFF_SLEEP_DUR_LOW);
    assign dur_value     = {dur_high_in, dur_low_in};
    assign sleep_start   = enable_two_reg[`BIT_SLEEP_START];

    // ------------------------------------------------------------
    // Duration as it stands after this cycle's write
    // ------------------------------------------------------------
    always_comb begin
        dur_high_in = dur_high_reg;
        dur_low_in  = dur_low_reg;
        if (wr_en && REG_ACCESS.addr == `OFF_SLEEP_DUR_HIGH) begin
            dur_high_in = REG_ACCESS.wdata;
        end
        if (wr_en && REG_ACCESS.addr == `OFF_SLEEP_DUR_LOW) begin
            dur_low_in = REG_ACCESS.wdata;
        end
    end

    // ------------------------------------------------------------
    // Register writes, soft clear and sleep timer
    // ------------------------------------------------------------
    always_comb begin
        enable_two_next = enable_two_reg;
        control_next    = control_reg;
        dur_high_next   = dur_high_reg;
        dur_low_next    = dur_low_reg;
        pin_mux_next    = pin_mux_reg;
        remain_next     = remain_reg;
        running_next    = running_reg;
        done_next       = done_reg;
        tick_cnt_next   = tick_cnt_reg;
        ms_tick         = 1'b0;
        if (running_reg) begin
            if (tick_cnt_reg >= 32'(MS_CYCLES - 1)) begin
                tick_cnt_next = '0;
                ms_tick       = 1'b1;
            end else begin
                tick_cnt_next = tick_cnt_reg + 32'd1;
            end
        end else begin
            tick_cnt_next = '0;
        end
        if (soft_clear) begin
            // Boost charge survives the clear
            enable_two_next = enable_two_reg & (8'h01 << `BIT_BOOST_CHARGE);
            control_next    = `RST_BYTE;
            dur_high_next   = `RST_BYTE;
            dur_low_next    = `RST_BYTE;
            pin_mux_next    = `RST_BYTE;
            running_next    = 1'b0;
            done_next       = 1'b0;
        end else if (wr_en) begin
            unique case (REG_ACCESS.addr)
                `OFF_ENABLE_TWO:     enable_two_next = REG_ACCESS.wdata & `MASK_ENABLE_TWO;
                `OFF_CONTROL:        control_next    = REG_ACCESS.wdata & `MASK_CONTROL & ~(8'h01 << `BIT_SOFT_CLEAR);
                `OFF_SLEEP_DUR_HIGH: dur_high_next   = REG_ACCESS.wdata;
                `OFF_SLEEP_DUR_LOW:  dur_low_next    = REG_ACCESS.wdata;
                `OFF_PIN_MUX:        pin_mux_next    = REG_ACCESS.wdata & `MASK_PIN_MUX;
                default: ;
            endcase
            if (start_written && !sleep_start && dur_value != `DUR_ZERO) begin
                running_next  = 1'b1;
                remain_next   = dur_value;
                tick_cnt_next = '0;
            end
            if (start_written) begin
                done_next = 1'b0;
            end
            if (sleep_start && !running_reg && dur_written && dur_value != `DUR_ZERO) begin
                running_next = 1'b1;
                remain_next  = dur_value;
            end
            if (wr_en && REG_ACCESS.addr == `OFF_ENABLE_TWO && !REG_ACCESS.wdata[`BIT_SLEEP_START]) begin
                running_next = 1'b0;
            end
        end
        if (running_reg && ms_tick && running_next && !start_written) begin
            // Counts from a latched copy, so duration edits wait for the next start
            if (remain_reg == `DUR_ONE) begin
                running_next = 1'b0;
                done_next    = 1'b1;
                enable_two_next[`BIT_SLEEP_START] = 1'b0;
            end else begin
                remain_next = remain_reg - 16'd1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            enable_two_reg <= `RST_BYTE;
            control_reg    <= `RST_BYTE;
            dur_high_reg   <= `RST_BYTE;
            dur_low_reg    <= `RST_BYTE;
            pin_mux_reg    <= `RST_BYTE;
            remain_reg     <= `DUR_ZERO;
            tick_cnt_reg   <= '0;
            running_reg    <= 1'b0;
            done_reg       <= 1'b0;
        end else begin
            enable_two_reg <= enable_two_next;
            control_reg    <= control_next;
            dur_high_reg   <= dur_high_next;
            dur_low_reg    <= dur_low_next;
            pin_mux_reg    <= pin_mux_next;
            remain_reg     <= remain_next;
            tick_cnt_reg   <= tick_cnt_next;
            running_reg    <= running_next;
            done_reg       <= done_next;
        end
    end

    // ------------------------------------------------------------
    // Boost charge phase and overtemperature flag
    // ------------------------------------------------------------
    always_comb begin
        charging_next   = enable_two_reg[`BIT_BOOST_CHARGE] && !BOOST_POWER_GOOD;
        otemp_flag_next = otemp_flag_reg
                          || (control_reg[`BIT_OVERTEMP_EN] && OVERTEMP_EVENT);
        if (soft_clear && !(control_reg[`BIT_OVERTEMP_EN] && OVERTEMP_EVENT)) begin
            otemp_flag_next = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            charging_reg   <= 1'b0;
            otemp_flag_reg <= 1'b0;
        end else begin
            charging_reg   <= charging_next;
            otemp_flag_reg <= otemp_flag_next;
        end
    end

    // ------------------------------------------------------------
    // Read back and block outputs
    // ------------------------------------------------------------
    logic          analog_off;
    logic          led_sel_in;
    logic          pin_level;
    pin_mode_type  pin_mode;

    assign analog_off = SLEEP_ANALOG_SHUTOFF && sleep_start;
    assign pin_mode   = pin_mode_type'(pin_mux_reg[`PIN_SEL_HI:`PIN_SEL_LO]);
    assign pin_level  = MPIN_IN;
    assign led_sel_in = enable_two_reg[`BIT_LED_SOURCE] ? LED_B_ENABLE_INPUT : LED_A_ENABLE_INPUT;

    always_comb begin
        unique case (REG_ACCESS.addr)
            `OFF_ENABLE_TWO:     REG_RDATA = enable_two_reg;
            `OFF_CONTROL:        REG_RDATA = control_reg;
            `OFF_SLEEP_DUR_HIGH: REG_RDATA = dur_high_reg;
            `OFF_SLEEP_DUR_LOW:  REG_RDATA = dur_low_reg;
            `OFF_PIN_MUX:        REG_RDATA = pin_mux_reg;
            default:             REG_RDATA = `RST_BYTE;
        endcase
    end

    always_comb begin
        MUX_SELECT = analog_off ? MUX_OFF : pin_mux_reg[`MUX_SEL_HI:`MUX_SEL_LO];
        BLOCK_CTRL.boost_on = BOOST_MAIN_ENABLE || charging_reg
            || (control_reg[`BIT_BROWNOUT_BOOST] && BROWNOUT_INDICATION);
        BLOCK_CTRL.led_block_on = enable_two_reg[`BIT_LED_PIN_GATE] && LED_ENABLE_PIN && led_sel_in;
        BLOCK_CTRL.horn_block_on = enable_two_reg[`BIT_HORN_EN] && HORN_ENABLE_PIN && !analog_off;
        BLOCK_CTRL.host_regulator_on = !control_reg[`BIT_REG_OFF];
        BLOCK_CTRL.brownout_monitor_on = !control_reg[`BIT_BROWNOUT_OFF];
        BLOCK_CTRL.fault_enter = (REGULATOR_ERROR && !control_reg[`BIT_REG_ERR_OFF])
            || (OVERTEMP_EVENT && control_reg[`BIT_OVERTEMP_EN]);
        BLOCK_CTRL.overtemp_error_flag = otemp_flag_reg;
        BLOCK_CTRL.mux_bypass_on = pin_mux_reg[`BIT_MUX_BYPASS];
        BLOCK_CTRL.mux_buffer_on = !pin_mux_reg[`BIT_MUX_BYPASS] && MUX_SELECT != MUX_OFF;
        BLOCK_CTRL.analog_shutoff = analog_off;
    end

    // ------------------------------------------------------------
    // Interconnect and multi-purpose pin
    // ------------------------------------------------------------
    always_comb begin
        // Interconnect forced off in analog shutoff
        INT_UNIT_OUT = INT_MCU_IN;
        INT_MCU_OUT  = INT_UNIT_IN;
        INT_UNIT_OE  = !analog_off && enable_two_reg[`BIT_INT_DIR];
        INT_MCU_OE   = !analog_off && !enable_two_reg[`BIT_INT_DIR];
        MPIN_OUT = ANY_UNMASKED_ERROR;
        MPIN_OE  = pin_mode == PIN_ERR_OUT;
        LED_A_ON = LED_A_ENABLE_INPUT || (pin_mode == PIN_OR_LED_A && pin_level);
        LED_B_ON = LED_B_ENABLE_INPUT || (pin_mode == PIN_OR_LED_B && pin_level);
        BATTERY_TEST_ON = !analog_off
            && (BATTERY_LOAD_ENABLE || (pin_mode == PIN_OR_BATTERY && pin_level));
    end

    // ------------------------------------------------------------
    // Sleep and soft clear status
    // ------------------------------------------------------------
    always_comb begin
        SLEEP_ACTIVE = running_reg;
        SLEEP_FINISHED_FLAG = done_reg;
        SOFT_CLEAR_PULSE = soft_clear;
    end
endmodule // afe_ctrl_sleep_regs

`default_nettype wire

//--- verification/afe_ctrl_sva.sv
// Purpose: Port-level assertions for the control register group
// Assumes: Bound onto afe_ctrl_sleep_regs, single clock domain
// Notes:   Combinational outputs are sampled at the rising edge
`timescale 1ns/1ps
`default_nettype none
module afe_ctrl_sva (
    input wire logic                         CLK,
    input wire logic                         RESETN,
    input wire afe_ctrl_pkg::reg_access_type REG_ACCESS,
    input wire logic [7:0]                   REG_RDATA,
    input wire logic                         ANY_UNMASKED_ERROR,
    input wire logic                         MPIN_OUT,
    input wire logic                         MPIN_OE,
    input wire logic                         BATTERY_TEST_ON,
    input wire logic [1:0]                   MUX_SELECT,
    input wire logic                         SLEEP_ACTIVE,
    input wire logic                         SLEEP_FINISHED_FLAG,
    input wire logic                         SOFT_CLEAR_PULSE,
    input wire afe_ctrl_pkg::block_ctrl_type BLOCK_CTRL
);
    import afe_ctrl_pkg::*;
    wire logic pin_wr = REG_ACCESS.write_en && REG_ACCESS.addr == 8'h0B;
    default clocking dcb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_RSVD_READ: assert property (REG_ACCESS.addr == 8'h07 |-> REG_RDATA[5:4] == 2'b00)
        else $error("reserved enable bits read nonzero");
    AST_SOFT_CAUSE: assert property (SOFT_CLEAR_PULSE |-> REG_ACCESS.write_en && REG_ACCESS.addr == 8'h08 && REG_ACCESS.wdata[1])
        else $error("soft clear without a write");
    AST_SOFT_EFFECT: assert property (SOFT_CLEAR_PULSE |=> !SLEEP_ACTIVE && !SLEEP_FINISHED_FLAG)
        else $error("sleep state survived soft clear");
    AST_PIN_DRIVE: assert property (MPIN_OE |-> MPIN_OUT == ANY_UNMASKED_ERROR)
        else $error("pin output does not follow error");
    AST_PIN_MODE: assert property (pin_wr |=> MPIN_OE == ($past(REG_ACCESS.wdata[2:0]) == 3'h2))
        else $error("pin drive does not match code");
    AST_SHUTOFF: assert property (BLOCK_CTRL.analog_shutoff |-> MUX_SELECT == 2'b00 && !BATTERY_TEST_ON && !BLOCK_CTRL.horn_block_on)
        else $error("analog blocks live during shutoff");
    AST_BYPASS: assert property (BLOCK_CTRL.mux_buffer_on == (!BLOCK_CTRL.mux_bypass_on && MUX_SELECT != 2'b00))
        else $error("buffer on while bypassed");
    AST_SLEEP_END: assert property ($rose(SLEEP_FINISHED_FLAG) |-> $fell(SLEEP_ACTIVE))
        else $error("done flag without sleep exit");
endmodule // afe_ctrl_sva
`default_nettype wire

//--- verification/host_port_model.sv
// Purpose: Host side of the byte register port
// Assumes: One-cycle write strobe, combinational read data
// Notes:   Tasks are called from the testbench
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    input  wire logic                         clk,
    input  wire logic [7:0]                   reg_rdata,
    output var afe_ctrl_pkg::reg_access_type  reg_access
);
    import afe_ctrl_pkg::*;
    initial reg_access = '{write_en: 1'b0, addr: 8'h00, wdata: 8'h00};
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_access = '{write_en: 1'b1, addr: a, wdata: d};
        @(posedge clk);
        // Stale byte must not look valid
        #1 reg_access = '{write_en: 1'b0, addr: a, wdata: ~d};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1 reg_access.addr = a;
        @(posedge clk);
        d = reg_rdata;
    endtask
endmodule // host_port_model
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: Self-checking bench for the control register group
// Assumes: Shortened millisecond tick
// Notes:   Host accesses go through host_port_model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import afe_ctrl_pkg::*;
    localparam int MS = 4;
    logic clk, resetn, shutoff, led_a, led_b, led_pin, horn_pin, boost_main_enable, boost_power_good, brownout;
    logic reg_err, ot_evt, any_err, bat_en, int_ui, int_mi, mpin_in, int_uo, int_uoe;
    logic int_mo, int_moe, mpin_out, mpin_oe, led_a_on, led_b_on, bat_on, slp_act, slp_flag, soft_pulse;
    logic [1:0]     mux_sel;
    logic [7:0]     rdata, rd;
    reg_access_type acc;
    block_ctrl_type blk;
    int             num_errors = 0;
    int             checks = 0;
    int             n;
    logic [7:0] ad [6] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
    logic [7:0] wd [6] = '{8'hFF, 8'hFD, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [7:0] ex [6] = '{8'hCF, 8'h3D, 8'hFF, 8'hFF, 8'hB7, 8'h00};
    logic [7:0] sc [6] = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] cw [6] = '{8'h00, 8'h30, 8'h00, 8'h08, 8'h04, 8'h01};
    logic [2:0] ci [6] = '{3'h3, 3'h0, 3'h4, 3'h4, 3'h2, 3'h1};
    logic [7:0] ce [6] = '{8'h18, 8'h00, 8'h1C, 8'h18, 8'h1D, 8'h1B};

    afe_ctrl_sleep_regs #(.MS_CYCLES(MS)) i_afe_ctrl_sleep_regs (.CLK(clk), .RESETN(resetn),
        .REG_ACCESS(acc), .REG_RDATA(rdata), .SLEEP_ANALOG_SHUTOFF(shutoff), .LED_A_ENABLE_INPUT(led_a),
        .LED_B_ENABLE_INPUT(led_b), .LED_ENABLE_PIN(led_pin), .HORN_ENABLE_PIN(horn_pin),
        .BOOST_MAIN_ENABLE(boost_main_enable), .BOOST_POWER_GOOD(boost_power_good), .BROWNOUT_INDICATION(brownout),
        .REGULATOR_ERROR(reg_err), .OVERTEMP_EVENT(ot_evt), .ANY_UNMASKED_ERROR(any_err),
        .BATTERY_LOAD_ENABLE(bat_en), .INT_UNIT_IN(int_ui), .INT_MCU_IN(int_mi), .INT_UNIT_OUT(int_uo),
        .INT_UNIT_OE(int_uoe), .INT_MCU_OUT(int_mo), .INT_MCU_OE(int_moe), .MPIN_IN(mpin_in),
        .MPIN_OUT(mpin_out), .MPIN_OE(mpin_oe), .LED_A_ON(led_a_on), .LED_B_ON(led_b_on),
        .BATTERY_TEST_ON(bat_on), .MUX_SELECT(mux_sel), .SLEEP_ACTIVE(slp_act),
        .SLEEP_FINISHED_FLAG(slp_flag), .SOFT_CLEAR_PULSE(soft_pulse), .BLOCK_CTRL(blk));
    host_port_model i_host_port_model (.clk(clk), .reg_rdata(rdata), .reg_access(acc));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host_port_model.write_reg(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host_port_model.read_reg(a, rd);
        chk(rd, exp);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic sleep_len(input int lo, input int hi);
        n = 0;
        while (slp_act === 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
        chk(8'(n >= lo && n <= hi), 8'h01);
    endtask
    task automatic give_verdict();
        $display("checks %0d, num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        $display("Error %0t: watchdog expired", $time);
        give_verdict();
    end
    // --------------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------------
    initial begin
        {resetn, shutoff, led_a, led_b, led_pin, horn_pin, boost_main_enable, boost_power_good} = 8'h00;
        {brownout, reg_err, ot_evt, any_err, bat_en, int_ui, int_mi, mpin_in} = 8'h00;
        tick(16);
        resetn = 1'b1;
        for (int i = 0; i < 6; i++) rchk(ad[i], 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(ad[i], wd[i]);
            rchk(ad[i], ex[i]);
        end
        wr(8'h08, 8'h02);
        for (int i = 0; i < 6; i++) rchk(ad[i], sc[i]);
        wr(8'h07, 8'h00);
        $display("test registers done");
        {mpin_in, any_err} = 2'b11;
        for (int c = 0; c < 8; c++) begin
            wr(8'h07, (c == 5) ? 8'h80 : 8'h00);
            wr(8'h0B, 8'(c));
            chk(8'({mpin_oe, mpin_out & mpin_oe, led_a_on, led_b_on, bat_on}), 8'({c == 2, c == 2, c == 4, c == 5, c == 7}));
        end
        for (int m = 0; m < 5; m++) begin
            wr(8'h0B, (m == 4) ? 8'hB0 : 8'(m << 4));
            chk(8'({mux_sel, blk.mux_buffer_on, blk.mux_bypass_on}), 8'((m == 4) ? 4'hD : {2'(m), m != 0, 1'b0}));
        end
        {horn_pin, led_pin, int_ui, int_mi, led_a} = 5'b11101;
        wr(8'h07, 8'h00);
        chk(8'({blk.horn_block_on, blk.led_block_on, int_uoe, int_moe, int_mo}), 8'h03);
        wr(8'h07, 8'h0E);
        chk(8'({blk.horn_block_on, blk.led_block_on, int_moe, int_uoe, int_uo}), 8'h1A);
        wr(8'h07, 8'h8E);
        chk(8'(blk.led_block_on), 8'h00);
        $display("test pins done");
        for (int i = 0; i < 6; i++) begin
            {reg_err, ot_evt, brownout} = ci[i];
            wr(8'h08, cw[i]);
            tick(2);
            chk(8'({blk.host_regulator_on, blk.brownout_monitor_on, blk.fault_enter, blk.boost_on,
                blk.overtemp_error_flag}), ce[i]);
        end
        brownout = 1'b0;
        wr(8'h08, 8'h00);
        wr(8'h07, 8'h40);
        tick(2);
        chk(8'(blk.boost_on), 8'h01);
        boost_power_good = 1'b1;
        tick(2);
        chk(8'(blk.boost_on), 8'h00);
        wr(8'h07, 8'h00);
        boost_main_enable = 1'b1;
        tick(1);
        chk(8'(blk.boost_on), 8'h01);
        $display("test control done");
        shutoff = 1'b1;
        wr(8'h0B, 8'h30);
        wr(8'h0A, 8'h03);
        wr(8'h07, 8'h01);
        chk(8'({slp_act, slp_flag, mux_sel}), 8'h08);
        wr(8'h0A, 8'h05);
        sleep_len(3 * MS - 3, 3 * MS - 1);
        chk(8'({slp_act, slp_flag, mux_sel}), 8'h07);
        rchk(8'h07, 8'h00);
        wr(8'h07, 8'h01);
        wr(8'h07, 8'h00);
        tick(1);
        chk(8'({slp_act, slp_flag}), 8'h00);
        wr(8'h0A, 8'h00);
        wr(8'h07, 8'h01);
        tick(20);
        chk(8'({slp_act, slp_flag}), 8'h00);
        rchk(8'h07, 8'h01);
        wr(8'h0A, 8'h02);
        sleep_len(2 * MS - 1, 2 * MS + 1);
        chk(8'(slp_flag), 8'h01);
        $display("test sleep done");
        give_verdict();
    end
endmodule // tb_top

bind afe_ctrl_sleep_regs afe_ctrl_sva i_afe_ctrl_sva (.CLK(CLK), .RESETN(RESETN), .REG_ACCESS(REG_ACCESS),
    .REG_RDATA(REG_RDATA), .ANY_UNMASKED_ERROR(ANY_UNMASKED_ERROR), .MPIN_OUT(MPIN_OUT), .MPIN_OE(MPIN_OE),
    .BATTERY_TEST_ON(BATTERY_TEST_ON), .MUX_SELECT(MUX_SELECT), .SLEEP_ACTIVE(SLEEP_ACTIVE),
    .SLEEP_FINISHED_FLAG(SLEEP_FINISHED_FLAG), .SOFT_CLEAR_PULSE(SOFT_CLEAR_PULSE), .BLOCK_CTRL(BLOCK_CTRL));
`default_nettype wire
